// file: sre_fifo.sv
`default_nettype none

module sre_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    assign in_ready = (count_r != FULL);
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push) begin
            wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
        end
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage needs no reset; empty flag masks stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

endmodule

`default_nettype wire

// file: sre_host_model.sv
`default_nettype none

module sre_host_model (
    // Pacing clock
    input wire logic clk,
    // Busy seen from every expander on the lines
    input wire logic busy,
    // Port lines
    output logic shift_clock,
    output logic serial_in,
    output logic output_gate
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        shift_clock = 1'b0;
        serial_in = 1'b0;
        output_gate = 1'b1;
    end

    task automatic set_gate(input logic g);
        @(negedge clk);
        output_gate = g;
    endtask

    // Race mode moves data in the same step as the clock edge
    task automatic shift_bit(input logic b, input logic race);
        int n;
        @(negedge clk);
        serial_in = b;
        repeat (3) @(negedge clk);
        shift_clock = 1'b1;
        if (race) begin
            serial_in = ~b;
        end
        repeat (3) @(negedge clk);
        shift_clock = 1'b0;
        n = 0;
        // Bounded, so a full buffer cannot hang the host
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
    endtask
endmodule

`default_nettype wire

// file: sre_params.svh
`ifndef SRE_PARAMS_SVH
`define SRE_PARAMS_SVH

// Register length of one expander unit
`define SRE_STAGES 10
// Word width and depth of the bit buffer between the link and the register
`define SRE_FIFO_WIDTH 1
`define SRE_FIFO_DEPTH 16
// Value every stage takes at power-up
`define SRE_CLEAR_BIT 1'b0
// Value the parallel outputs show while gated off
`define SRE_GATED_BIT 1'b0
// Level of the shift clock pin that counts as logic 1
`define SRE_CLK_HIGH 1'b1
// Level of the gate pin that enables the parallel outputs
`define SRE_GATE_ON 1'b1

`endif

// file: sre_pkg.sv
`default_nettype none

package sre_pkg;

    // Link side capture state
    typedef enum logic {
        SRE_IDLE,
        SRE_WAIT
    } sre_link_e;

endpackage

`default_nettype wire

// file: sre_top.sv
// Summary of operation
// - Ten stages, parallel outputs, serial output last
// - Shift clock rising edge shifts one bit
// - Bit before the edge captured, no race
// - Gate high shows stages, low forces zero
// - Serial output ignores the gate
// - Units chain serial out to serial in
// - Power-up clears every stage to zero
// - Fully static, holds contents while clock idle
`default_nettype none

`include "sre_params.svh"

module sre_top #(
    parameter int STAGES = `SRE_STAGES,
    parameter int FIFO_DEPTH = `SRE_FIFO_DEPTH
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link sampling clock
    input wire logic link_clk,
    // Host port lines
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic output_gate,
    // User side
    input wire logic shift_hold,
    output logic [STAGES-1:0] par_out,
    output logic serial_out,
    output logic link_busy
);

    // ------------------------------------------------------------------
    // Link domain: sample the shift clock and data lines and capture one bit per edge
    // ------------------------------------------------------------------
    logic sclk_s1_r;
    logic sclk_s2_r;
    logic sclk_prev_r;
    logic din_s1_r;
    logic din_s2_r;
    logic din_d3_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_prev_r;
    logic req_tgl_r;
    logic req_tgl_nxt;
    logic bit_r;
    logic bit_nxt;
    logic busy_r;
    logic busy_nxt;
    sre_pkg::sre_link_e state_r;
    sre_pkg::sre_link_e state_nxt;
    logic sclk_rise;
    logic ack_seen;
    logic ack_tgl;

    // Both pins get two flops; data gets a third so it lags the clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sclk_s1_r <= `SRE_CLEAR_BIT;
            sclk_s2_r <= `SRE_CLEAR_BIT;
            sclk_prev_r <= `SRE_CLEAR_BIT;
            din_s1_r <= `SRE_CLEAR_BIT;
            din_s2_r <= `SRE_CLEAR_BIT;
            din_d3_r <= `SRE_CLEAR_BIT;
            ack_s1_r <= `SRE_CLEAR_BIT;
            ack_s2_r <= `SRE_CLEAR_BIT;
            ack_prev_r <= `SRE_CLEAR_BIT;
        end else begin
            sclk_s1_r <= shift_clock;
            sclk_s2_r <= sclk_s1_r;
            sclk_prev_r <= sclk_s2_r;
            din_s1_r <= serial_in;
            din_s2_r <= din_s1_r;
            din_d3_r <= din_s2_r;
            ack_s1_r <= ack_tgl;
            ack_s2_r <= ack_s1_r;
            ack_prev_r <= ack_s2_r;
        end
    end

    assign sclk_rise = (sclk_s2_r == `SRE_CLK_HIGH) && (sclk_prev_r != `SRE_CLK_HIGH);
    assign ack_seen = (ack_s2_r != ack_prev_r);

    always_comb begin
        state_nxt = state_r;
        req_tgl_nxt = req_tgl_r;
        bit_nxt = bit_r;
        busy_nxt = busy_r;
        unique case (state_r)
            sre_pkg::SRE_IDLE: begin
                if (sclk_rise) begin
                    // Delayed data sample holds the level before the edge
                    bit_nxt = din_d3_r;
                    req_tgl_nxt = !req_tgl_r;
                    busy_nxt = 1'b1;
                    state_nxt = sre_pkg::SRE_WAIT;
                end
            end
            sre_pkg::SRE_WAIT: begin
                // Bit stays frozen until the system side owns it
                if (ack_seen) begin
                    busy_nxt = 1'b0;
                    state_nxt = sre_pkg::SRE_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state_r <= sre_pkg::SRE_IDLE;
            req_tgl_r <= `SRE_CLEAR_BIT;
            bit_r <= `SRE_CLEAR_BIT;
            busy_r <= `SRE_CLEAR_BIT;
        end else begin
            state_r <= state_nxt;
            req_tgl_r <= req_tgl_nxt;
            bit_r <= bit_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Edges arriving while busy are lost; host pace is far slower
    assign link_busy = busy_r;

    // ------------------------------------------------------------------
    // System domain: take the bit, buffer it, shift the register
    // ------------------------------------------------------------------
    logic req_s1_r;
    logic req_s2_r;
    logic req_prev_r;
    logic req_prev_nxt;
    logic gate_s1_r;
    logic gate_s2_r;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`SRE_FIFO_WIDTH-1:0] fifo_out_data;
    logic push;
    logic pop;
    logic [STAGES-1:0] stages_r;
    logic [STAGES-1:0] stages_nxt;
    logic [STAGES-1:0] par_r;
    logic [STAGES-1:0] par_nxt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_s1_r <= `SRE_CLEAR_BIT;
            req_s2_r <= `SRE_CLEAR_BIT;
            gate_s1_r <= `SRE_CLEAR_BIT;
            gate_s2_r <= `SRE_CLEAR_BIT;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            gate_s1_r <= output_gate;
            gate_s2_r <= gate_s1_r;
        end
    end

    // A pending toggle stays valid until the buffer accepts it
    assign fifo_in_valid = (req_s2_r != req_prev_r);
    assign push = fifo_in_valid && fifo_in_ready;
    assign ack_tgl = req_prev_r;

    always_comb begin
        req_prev_nxt = req_prev_r;
        if (push) begin
            req_prev_nxt = req_s2_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_prev_r <= `SRE_CLEAR_BIT;
        end else begin
            req_prev_r <= req_prev_nxt;
        end
    end

    sre_fifo #(
        .WIDTH(`SRE_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(bit_r),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Hold stalls the register; bits queue up in the buffer meanwhile
    assign fifo_out_ready = !shift_hold;
    assign pop = fifo_out_valid && fifo_out_ready;

    always_comb begin
        // Static: no shift without a bit, contents kept indefinitely
        stages_nxt = stages_r;
        if (pop) begin
            stages_nxt = {stages_r[STAGES-2:0], fifo_out_data[0]};
        end
        par_nxt = (gate_s2_r == `SRE_GATE_ON) ? stages_r : {STAGES{`SRE_GATED_BIT}};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stages_r <= {STAGES{`SRE_CLEAR_BIT}};
            par_r <= {STAGES{`SRE_CLEAR_BIT}};
        end else begin
            stages_r <= stages_nxt;
            par_r <= par_nxt;
        end
    end

    assign par_out = par_r;
    // Not gated, so a chain keeps shifting with outputs off
    assign serial_out = stages_r[STAGES-1];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic shifted_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shifted_r <= 1'b0;
        end else if (pop) begin
            shifted_r <= 1'b1;
        end
    end

    edge_capture_a: assert property (
        @(posedge link_clk) disable iff (rst)
        (state_r == sre_pkg::SRE_IDLE) && sclk_rise
        |=> (bit_r == $past(din_d3_r)) && (state_r == sre_pkg::SRE_WAIT)
    ) else $error("captured bit is not the pre-edge sample");

    one_request_a: assert property (
        @(posedge link_clk) disable iff (rst)
        (state_r == sre_pkg::SRE_WAIT) && !ack_seen
        |=> $stable(bit_r) && $stable(req_tgl_r) && busy_r
    ) else $error("request changed while waiting");

    no_edge_no_req_a: assert property (
        @(posedge link_clk) disable iff (rst)
        !sclk_rise |=> $stable(req_tgl_r)
    ) else $error("request toggled without a clock edge");

    single_push_a: assert property (
        @(posedge clk) disable iff (rst)
        push |=> !fifo_in_valid
    ) else $error("one request pushed more than once");

    shift_step_a: assert property (
        @(posedge clk) disable iff (rst)
        pop |=> (stages_r[STAGES-1:1] == $past(stages_r[STAGES-2:0]))
            && (stages_r[0] == $past(fifo_out_data[0]))
    ) else $error("register did not shift by one stage");

    static_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        !pop [*2] |-> $stable(stages_r)
    ) else $error("register changed without a shift");

    gate_off_zero_a: assert property (
        @(posedge clk) disable iff (rst)
        !gate_s2_r |=> (par_out == '0)
    ) else $error("parallel outputs not forced low");

    gate_on_copy_a: assert property (
        @(posedge clk) disable iff (rst)
        gate_s2_r |=> (par_out == $past(stages_r))
    ) else $error("parallel outputs do not show the register");

    serial_ungated_a: assert property (
        @(posedge clk) disable iff (rst)
        pop && !gate_s2_r |=> (serial_out == $past(stages_r[STAGES-2]))
    ) else $error("serial output stalled while gated off");

    power_clear_a: assert property (
        @(posedge clk) disable iff (rst)
        !shifted_r |-> (stages_r == '0) && (par_out == '0)
    ) else $error("register not clear before first shift");

    busy_set_a: assert property (
        @(posedge link_clk) disable iff (rst)
        (state_r == sre_pkg::SRE_IDLE) && sclk_rise
        |=> busy_r && (req_tgl_r != $past(req_tgl_r))
    ) else $error("captured edge raised no request");

    busy_release_a: assert property (
        @(posedge link_clk) disable iff (rst)
        (state_r == sre_pkg::SRE_WAIT) && ack_seen
        |=> !busy_r && (state_r == sre_pkg::SRE_IDLE)
    ) else $error("link stayed busy after the acknowledge");

    serial_shift_a: assert property (
        @(posedge clk) disable iff (rst)
        pop |=> (serial_out == $past(stages_r[STAGES-2]))
    ) else $error("serial output did not take the next stage");

    hold_freeze_a: assert property (
        @(posedge clk) disable iff (rst)
        shift_hold |=> $stable(stages_r)
    ) else $error("register shifted while held");

    pending_kept_a: assert property (
        @(posedge clk) disable iff (rst)
        fifo_in_valid && !fifo_in_ready |=> fifo_in_valid
    ) else $error("pending bit dropped while the buffer was full");

    push_to_shift_a: assert property (
        @(posedge clk) disable iff (rst)
        (push && !fifo_out_valid) ##1 !shift_hold |-> pop
    ) else $error("accepted bit did not shift the register");

    shift_gated_c: cover property (
        @(posedge clk) disable iff (rst)
        pop && gate_s2_r ##1 (par_out != '0)
    );

    buffer_full_c: cover property (
        @(posedge clk) disable iff (rst)
        fifo_in_valid && !fifo_in_ready
    );

    chain_out_c: cover property (
        @(posedge clk) disable iff (rst)
        !gate_s2_r && serial_out
    );

    lost_edge_c: cover property (
        @(posedge link_clk) disable iff (rst)
        (state_r == sre_pkg::SRE_WAIT) && sclk_rise
    );

endmodule

`default_nettype wire

// file: tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic shift_hold = 1'b0;
    logic shift_clock;
    logic serial_in;
    logic output_gate;
    logic [9:0] par_out;
    logic [9:0] chain_par;
    logic serial_out;
    logic link_busy;
    logic chain_busy;
    logic any_busy;
    logic [19:0] exp_bits = 20'h00000;
    logic [9:0] held;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #10 clk = ~clk;
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    assign any_busy = link_busy | chain_busy;

    sre_top u_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .shift_clock(shift_clock),
        .serial_in(serial_in), .output_gate(output_gate), .shift_hold(shift_hold),
        .par_out(par_out), .serial_out(serial_out), .link_busy(link_busy));
    // Second unit fed from the first one's serial output
    sre_top u_chain (.clk(clk), .rst(rst), .link_clk(link_clk), .shift_clock(shift_clock),
        .serial_in(serial_out), .output_gate(output_gate), .shift_hold(1'b0),
        .par_out(chain_par), .serial_out(), .link_busy(chain_busy));
    sre_host_model u_host (.clk(clk), .busy(any_busy), .shift_clock(shift_clock),
        .serial_in(serial_in), .output_gate(output_gate));

    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input logic [9:0] got, input logic [9:0] want);
        samples_checked++;
        if (got !== want) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic push(input logic b, input logic race);
        u_host.shift_bit(b, race);
        exp_bits = {exp_bits[18:0], b};
    endtask

    task automatic test_reset();
        check(par_out, 10'h000);
        check({9'h000, serial_out}, 10'h000);
        check(chain_par, 10'h000);
    endtask

    task automatic test_pattern();
        logic [19:0] pat;
        pat = 20'hA5C36;
        for (int i = 19; i >= 0; i--) begin
            push(pat[i], 1'b0);
            check(par_out, exp_bits[9:0]);
            check({9'h000, serial_out}, {9'h000, exp_bits[9]});
            check(chain_par, exp_bits[19:10]);
        end
    endtask

    task automatic test_race();
        logic [9:0] pat;
        pat = 10'h3A6;
        for (int i = 9; i >= 0; i--) begin
            push(pat[i], 1'b1);
            check(par_out, exp_bits[9:0]);
        end
    endtask

    task automatic test_gate();
        u_host.set_gate(1'b0);
        repeat (5) @(negedge clk);
        check(par_out, 10'h000);
        push(~exp_bits[0], 1'b0);
        check(par_out, 10'h000);
        check({9'h000, serial_out}, {9'h000, exp_bits[9]});
        // Long idle with the clock low must not disturb the stages
        repeat (500) @(negedge clk);
        u_host.set_gate(1'b1);
        repeat (5) @(negedge clk);
        check(par_out, exp_bits[9:0]);
    endtask

    task automatic test_walk();
        for (int i = 0; i < 20; i++) begin
            push(i == 10, 1'b0);
            if (i >= 10) begin
                check(par_out, 10'h001 << (i - 10));
            end
        end
        push(1'b0, 1'b0);
        check(chain_par, 10'h001);
    endtask

    task automatic test_fifo();
        int n;
        @(negedge clk);
        shift_hold = 1'b1;
        held = exp_bits[9:0];
        for (int i = 0; i < 16; i++) begin
            push(i[0] ^ i[2], 1'b0);
            check({9'h000, link_busy}, 10'h000);
            check(par_out, held);
        end
        // Buffer full: next edge stays pending
        push(1'b1, 1'b0);
        check({9'h000, link_busy}, 10'h001);
        check(par_out, held);
        // Edge while busy is refused: no shift, nothing queued
        u_host.shift_bit(1'b0, 1'b0);
        check({9'h000, link_busy}, 10'h001);
        check(par_out, held);
        @(negedge clk);
        shift_hold = 1'b0;
        n = 0;
        while (link_busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        repeat (30) @(negedge clk);
        check(par_out, exp_bits[9:0]);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        test_reset();
        test_pattern();
        test_race();
        test_gate();
        test_walk();
        test_fifo();
        give_verdict();
    end
endmodule

`default_nettype wire
